// ### rtl/intr_resolve_pkg.sv
/*
  constants, source table and carrier types for the interrupt vector resolver.
  assumes request and field inputs arrive from logic on the same clock.
*/
package intr_resolve_pkg;

  localparam int NUM_SRC    = 17;
  localparam int NUM_FIELD  = 9;
  localparam int FIELD_W    = 3;
  localparam int LVL_W      = 4;
  localparam int VEC_W      = 8;
  localparam int ADDR_W     = 16;
  localparam int IDX_W      = 5;
  localparam int FSEL_W     = 4;
  localparam int ADDR_SHIFT = 2;

  // source index; index order equals vector order
  localparam int SRC_NMI  = 0;
  localparam int SRC_EXT0 = 1;
  localparam int SRC_ADC  = 11;

  localparam logic [LVL_W-1:0] NMI_LEVEL = 4'h8;

  // vector number of each source, index 16 first
  localparam logic [NUM_SRC-1:0][VEC_W-1:0] SRC_VECTOR = {
    8'h24, 8'h23, 8'h22, 8'h21, 8'h20, 8'h1C, 8'h19, 8'h18,
    8'h17, 8'h16, 8'h15, 8'h14, 8'h13, 8'h12, 8'h11, 8'h10, 8'h07};

  // module priority field serving each source, index 16 first
  localparam logic [NUM_SRC-1:0][FSEL_W-1:0] SRC_FIELD = {
    4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h7, 4'h6, 4'h5,
    4'h4, 4'h4, 4'h3, 4'h3, 4'h2, 4'h2, 4'h1, 4'h0, 4'h0};

  // sources allowed to start the transfer controller
  localparam logic [NUM_SRC-1:0] XFER_CAPABLE = 17'h0FBFE;

  // system vectors below 16 that are never produced
  localparam logic [15:0] RESERVED_VEC_MASK = 16'hF05E;

  localparam logic [VEC_W-1:0] VEC_EXT_FIRST = 8'h10;
  localparam logic [VEC_W-1:0] VEC_EXT_LAST  = 8'h17;
  localparam logic [VEC_W-1:0] VEC_LOW_END   = 8'h10;

  // packed so that bit i is source index i
  typedef struct packed {
    logic       timer0_overflow_request;
    logic [3:0] timer0_capture_match_request;
    logic       conversion_end_request;
    logic       watchdog_interval_request;
    logic       software_transfer_end_request;
    logic [7:0] external_request_line;
    logic       nmi_request;
  } src_req_t;

  typedef struct packed {
    logic              valid;
    logic [VEC_W-1:0]  num;
    logic [ADDR_W-1:0] addr;
    logic [LVL_W-1:0]  level;
  } grant_t;

  typedef logic [NUM_FIELD-1:0][FIELD_W-1:0] field_set_t;

endpackage

// ### rtl/priority_pick.sv
/*
  combinational pick of the highest level among pending requests.
  ties go to the lowest index; caller orders indices by vector number.
*/
`timescale 1ns/1ps
module priority_pick #(
  parameter int N     = 17,
  parameter int LVL_W = 4,
  parameter int IDX_W = 5
) (
  input  wire logic [N-1:0]            req_i,
  input  wire logic [N-1:0][LVL_W-1:0] level_i,
  output logic                         found_o,
  output logic [IDX_W-1:0]             idx_o,
  output logic [LVL_W-1:0]             level_o
);

  always_comb begin
    found_o = 1'b0;
    idx_o   = '0;
    level_o = '0;
    for (int i = 0; i < N; i++) begin
      if (req_i[i] && (!found_o || level_i[i] > level_o)) begin
        found_o = 1'b1;
        idx_o   = IDX_W'(i);
        level_o = level_i[i];
      end
    end
  end

endmodule // priority_pick

// ### rtl/intr_vector_resolver.sv
/*
  interrupt vector priority resolver: ranks pending sources into one cpu
  winner and one transfer controller winner, with vector number and address.
  assumes edge/level detection, enables and flags live upstream on core_clk_i.
*/
// Summary of operation
// - vector address is four times vector number
// - default: smaller vector number wins
// - programmed module levels rank before fixed order
// - equal levels: lower-numbered module wins
// - within one module, fixed vector order
// - only capable sources may start transfer controller
// - external lines 0-7 map to vectors 16-23
// - conversion end on vector 28, may start transfers
// - reserved system vectors are never produced
// - nmi vector 7, level 8, ignores mask
// - each field sets one of eight levels
// - transfer starts ignore cpu mask
`timescale 1ns/1ps
module intr_vector_resolver
  import intr_resolve_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       resetn_i,
  input  wire src_req_t   src_req_i,
  input  wire src_req_t   xfer_enable_i,
  input  wire field_set_t module_priority_field_i,
  input  wire logic [2:0] cpu_mask_level_i,
  output grant_t          cpu_grant_o,
  output grant_t          xfer_grant_o
);

  logic [NUM_SRC-1:0][LVL_W-1:0] level;
  logic [NUM_SRC-1:0]            req_vec;
  logic [NUM_SRC-1:0]            xfer_cand;
  logic [NUM_SRC-1:0]            cpu_cand;
  logic                          cpu_found;
  logic                          xfer_found;
  logic [IDX_W-1:0]              cpu_idx;
  logic [IDX_W-1:0]              xfer_idx;
  logic [LVL_W-1:0]              cpu_lvl;
  logic [LVL_W-1:0]              xfer_lvl;
  grant_t                        next_cpu_grant;
  grant_t                        next_xfer_grant;

  assign req_vec = src_req_i;

  // per-source level from its module field; nmi fixed at NMI_LEVEL
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      if (i == SRC_NMI) begin
        level[i] = NMI_LEVEL;
      end else begin
        level[i] = {1'b0, module_priority_field_i[SRC_FIELD[i]]};
      end
    end
  end

  // split requests between transfer controller and cpu
  assign xfer_cand = req_vec & xfer_enable_i & XFER_CAPABLE;

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      cpu_cand[i] = req_vec[i] && !xfer_cand[i] &&
                    (i == SRC_NMI || level[i] > {1'b0, cpu_mask_level_i});
    end
  end

  // level first, then vector order
  priority_pick #(.N(NUM_SRC), .LVL_W(LVL_W), .IDX_W(IDX_W)) u_pick_cpu (
    .req_i   (cpu_cand),
    .level_i (level),
    .found_o (cpu_found),
    .idx_o   (cpu_idx),
    .level_o (cpu_lvl)
  );

  // mask plays no part here
  priority_pick #(.N(NUM_SRC), .LVL_W(LVL_W), .IDX_W(IDX_W)) u_pick_xfer (
    .req_i   (xfer_cand),
    .level_i (level),
    .found_o (xfer_found),
    .idx_o   (xfer_idx),
    .level_o (xfer_lvl)
  );

  always_comb begin
    next_cpu_grant       = '0;
    next_cpu_grant.valid = cpu_found;
    if (cpu_found) begin
      next_cpu_grant.num   = SRC_VECTOR[cpu_idx];
      next_cpu_grant.addr  = ADDR_W'(SRC_VECTOR[cpu_idx]) << ADDR_SHIFT;
      next_cpu_grant.level = cpu_lvl;
    end
  end

  always_comb begin
    next_xfer_grant       = '0;
    next_xfer_grant.valid = xfer_found;
    if (xfer_found) begin
      next_xfer_grant.num   = SRC_VECTOR[xfer_idx];
      next_xfer_grant.addr  = ADDR_W'(SRC_VECTOR[xfer_idx]) << ADDR_SHIFT;
      next_xfer_grant.level = xfer_lvl;
    end
  end

  // cpu winner register
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cpu_grant_o <= '0;
    end else begin
      cpu_grant_o <= next_cpu_grant;
    end
  end

  // transfer controller winner register
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      xfer_grant_o <= '0;
    end else begin
      xfer_grant_o <= next_xfer_grant;
    end
  end

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  logic [7:0] past_ext;
  always_ff @(posedge core_clk_i) begin
    past_ext <= src_req_i.external_request_line;
  end

  // antecedents also need reset released at the sampling edge
  sequence s_two_ext_low;
    resetn_i && cpu_cand == 17'h00006;
  endsequence

  sequence s_adc_to_xfer;
    resetn_i && req_vec == 17'h00800 && xfer_enable_i.conversion_end_request;
  endsequence

  sequence s_nmi_pending;
    resetn_i && src_req_i.nmi_request;
  endsequence

  a_addr_times_four: assert property (
    cpu_grant_o.valid |-> cpu_grant_o.addr == (ADDR_W'(cpu_grant_o.num) << ADDR_SHIFT))
    else $error("cpu vector address is not four times the number");

  a_xfer_addr_four: assert property (
    xfer_grant_o.valid
    |-> xfer_grant_o.addr == (ADDR_W'(xfer_grant_o.num) << ADDR_SHIFT))
    else $error("transfer vector address is not four times the number");

  a_equal_field_order: assert property (
    resetn_i && cpu_cand == 17'h00802 && level[SRC_EXT0] == level[SRC_ADC]
    |=> cpu_grant_o.num == VEC_EXT_FIRST)
    else $error("lower vector did not win at equal level");

  a_field_overrides: assert property (
    s_two_ext_low ##0 level[2] > level[1] |=> cpu_grant_o.num == 8'h11)
    else $error("higher programmed level did not win");

  a_tie_lower_module: assert property (
    s_two_ext_low ##0 level[2] == level[1] |=> cpu_grant_o.num == VEC_EXT_FIRST)
    else $error("tie not broken toward lower module");

  a_shared_field_order: assert property (
    resetn_i && cpu_cand == 17'h00018 |=> cpu_grant_o.valid ##0 cpu_grant_o.num == 8'h12)
    else $error("order inside shared field wrong");

  a_xfer_capable_only: assert property (
    xfer_grant_o.valid |-> xfer_grant_o.num != 8'h19 && xfer_grant_o.num != 8'h24
                           && xfer_grant_o.num != 8'h07)
    else $error("incapable source started transfer controller");

  a_xfer_not_cpu: assert property (
    resetn_i && xfer_cand[SRC_ADC]
    |=> !(cpu_grant_o.valid && cpu_grant_o.num == SRC_VECTOR[SRC_ADC]))
    else $error("transfer-routed source also reached the cpu");

  a_ext_vector_map: assert property (
    cpu_grant_o.valid && cpu_grant_o.num >= VEC_EXT_FIRST && cpu_grant_o.num <= VEC_EXT_LAST
    |-> past_ext[cpu_grant_o.num[2:0]])
    else $error("external vector without its request line");

  a_adc_xfer_vector: assert property (
    s_adc_to_xfer |=> xfer_grant_o.valid && xfer_grant_o.num == 8'h1C
                      && xfer_grant_o.addr == 16'h0070 && !cpu_grant_o.valid)
    else $error("conversion end did not start transfer on vector 28");

  a_no_reserved_vec: assert property (
    cpu_grant_o.valid && cpu_grant_o.num < VEC_LOW_END
    |-> !RESERVED_VEC_MASK[cpu_grant_o.num[3:0]])
    else $error("reserved system vector produced");

  a_nmi_always_wins: assert property (
    s_nmi_pending |=> cpu_grant_o.valid && cpu_grant_o.num == 8'h07
                      && cpu_grant_o.level == NMI_LEVEL)
    else $error("nmi not granted at level 8");

  a_field_to_level: assert property (
    cpu_grant_o.valid && cpu_grant_o.num == 8'h1C
    |-> cpu_grant_o.level == {1'b0, $past(module_priority_field_i[7])})
    else $error("granted level differs from module field");

  a_mask_gates_cpu: assert property (
    cpu_grant_o.valid && cpu_grant_o.num != SRC_VECTOR[SRC_NMI]
    |-> cpu_grant_o.level > {1'b0, $past(cpu_mask_level_i)})
    else $error("cpu grant at or below mask level");

  a_xfer_ignores_mask: assert property (
    resetn_i && (|xfer_cand) |=> xfer_grant_o.valid)
    else $error("transfer start blocked");

  a_idle_grant_zero: assert property (
    !cpu_grant_o.valid |-> cpu_grant_o.num == '0 && cpu_grant_o.addr == '0
                           && cpu_grant_o.level == '0)
    else $error("idle cpu grant carries stale fields");

  a_idle_xfer_zero: assert property (
    !xfer_grant_o.valid |-> xfer_grant_o.num == '0 && xfer_grant_o.addr == '0
                            && xfer_grant_o.level == '0)
    else $error("idle transfer grant carries stale fields");

  a_reset_clears_grants: assert property (
    disable iff (1'b0) !resetn_i |=> !cpu_grant_o.valid && !xfer_grant_o.valid)
    else $error("grant valid after reset");

endmodule // intr_vector_resolver

// ### verif/cpu_dtc_model.sv
/*
  cpu side model: fetches the handler address from each valid cpu grant.
  assumes grants are registered on core_clk_i.
*/
`timescale 1ns/1ps
module cpu_xfer_model
  import intr_resolve_pkg::*;
(
  input  wire logic         core_clk_i,
  input  wire logic         resetn_i,
  input  wire grant_t       cpu_grant_i,
  output logic [ADDR_W-1:0] fetch_addr_o,
  output logic              bad_vec_o
);
  // fetch only while a winner is flagged
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i)
      fetch_addr_o <= 16'h0000;
    else if (cpu_grant_i.valid)
      fetch_addr_o <= cpu_grant_i.addr;
  end
  // flag any system vector other than nmi
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i)
      bad_vec_o <= 1'b0;
    else if (cpu_grant_i.valid && cpu_grant_i.num < 8'h10 && cpu_grant_i.num != 8'h07)
      bad_vec_o <= 1'b1;
  end
endmodule // cpu_xfer_model

// ### verif/intr_vector_resolver_tb.sv
/*
  testbench for the interrupt vector resolver.
  assumes one-cycle registered grants and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module intr_vector_resolver_tb
  import intr_resolve_pkg::*;
();
  logic              core_clk_i = 1'b0;
  logic              resetn_i   = 1'b0;
  src_req_t          req        = '0;
  src_req_t          en         = '0;
  field_set_t        fld        = '0;
  logic [2:0]        mask       = 3'h0;
  grant_t            cpu_g;
  grant_t            xfer_g;
  logic [ADDR_W-1:0] fetch;
  logic              bad_vec;
  int                bad_count  = 0;
  int                cmp_count  = 0;

  initial forever #4 core_clk_i = ~core_clk_i;

  intr_vector_resolver u_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .src_req_i(req), .xfer_enable_i(en), .module_priority_field_i(fld),
    .cpu_mask_level_i(mask), .cpu_grant_o(cpu_g), .xfer_grant_o(xfer_g));
  cpu_xfer_model u_cpu (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .cpu_grant_i(cpu_g), .fetch_addr_o(fetch), .bad_vec_o(bad_vec));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic grant_t mk(input logic [7:0] n, input logic [3:0] l);
    mk = '{1'b1, n, {6'h00, n, 2'h0}, l};
  endfunction

  task automatic apply(input src_req_t r, input src_req_t e, input logic [2:0] m,
                       input field_set_t f);
    @(posedge core_clk_i);
    req <= r;
    en <= e;
    mask <= m;
    fld <= f;
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic t_nmi();
    apply(17'h00005, 17'h00001, 3'h7, {9{3'h4}});
    check(32'(cpu_g), 32'(mk(8'h07, 4'h8)));
    check(32'(xfer_g), 32'h0);
    @(posedge core_clk_i);
    #1;
    check(32'(fetch), 32'h001C);
    $display("nmi test done");
  endtask

  task automatic t_ext();
    for (int i = 0; i < 8; i++) begin
      apply(17'h00001 << (i + 1), 17'h0, 3'h4, {9{3'h5}});
      check(32'(cpu_g), 32'(mk(8'h10 + 8'(i), 4'h5)));
    end
    $display("external line test done");
  endtask

  task automatic t_order();
    apply(17'h00810, 17'h0, 3'h0, {9{3'h3}});
    check(32'(cpu_g), 32'(mk(8'h13, 4'h3)));
    apply(17'h00018, 17'h0, 3'h0, {{6{3'h3}}, 3'h6, 3'h3, 3'h3});
    check(32'(cpu_g), 32'(mk(8'h12, 4'h6)));
    apply(17'h00802, 17'h0, 3'h0, {3'h0, 3'h7, {6{3'h0}}, 3'h1});
    check(32'(cpu_g), 32'(mk(8'h1C, 4'h7)));
    apply(17'h1FFFE, 17'h0, 3'h0, {9{3'h2}});
    check(32'(cpu_g), 32'(mk(8'h10, 4'h2)));
    apply(17'h00802, 17'h0, 3'h0, {9{3'h3}});
    check(32'(cpu_g), 32'(mk(8'h10, 4'h3)));
    apply(17'h00006, 17'h0, 3'h0, {{7{3'h0}}, 3'h6, 3'h2});
    check(32'(cpu_g), 32'(mk(8'h11, 4'h6)));
    apply(17'h00006, 17'h0, 3'h0, {9{3'h3}});
    check(32'(cpu_g), 32'(mk(8'h10, 4'h3)));
    apply(17'h1F200, 17'h0, 3'h0, {3'h4, {2{3'h0}}, 3'h1, {5{3'h0}}});
    check(32'(cpu_g), 32'(mk(8'h20, 4'h4)));
    apply(17'h10000, 17'h0, 3'h0, {3'h1, {8{3'h0}}});
    check(32'(cpu_g), 32'(mk(8'h24, 4'h1)));
    $display("priority test done");
  endtask

  task automatic t_xfer();
    apply(17'h00C00, 17'h00C00, 3'h6, {3'h0, 3'h2, 3'h7, {6{3'h0}}});
    check(32'(xfer_g), 32'(mk(8'h1C, 4'h2)));
    check(32'(cpu_g), 32'(mk(8'h19, 4'h7)));
    apply(17'h10002, 17'h10002, 3'h7, {3'h5, {8{3'h1}}});
    check(32'(xfer_g), 32'(mk(8'h10, 4'h1)));
    check(32'(cpu_g), 32'h0);
    apply(17'h00800, 17'h00800, 3'h0, {3'h0, 3'h3, {7{3'h0}}});
    check(32'(xfer_g), 32'(mk(8'h1C, 4'h3)));
    check(32'(cpu_g), 32'h0);
    $display("transfer controller test done");
  endtask

  task automatic t_reset();
    apply(17'h00001, 17'h0, 3'h0, {9{3'h0}});
    @(posedge core_clk_i);
    resetn_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    check(32'(cpu_g), 32'h0);
    @(posedge core_clk_i);
    resetn_i <= 1'b1;
    #1;
    check(32'(cpu_g), 32'h0);
    check(32'(xfer_g), 32'h0);
    check(32'(fetch), 32'h0);
    @(posedge core_clk_i);
    #1;
    check(32'(cpu_g), 32'(mk(8'h07, 4'h8)));
    $display("mid-run reset test done");
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    t_nmi();
    t_ext();
    t_order();
    t_xfer();
    check(32'(bad_vec), 32'h0);
    t_reset();
    report_and_stop();
  end
endmodule // intr_vector_resolver_tb
